// *** verilog/fklwe_core.sv ***
// processor-side end: APB registers that issue key and move writes
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`include "fklwe_defs.svh"
module fklwe_core
  import fklwe_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic system_reset_req,
  fklwe_if.core bus
);
  logic we_bit;
  logic ee_bit;
  logic key_wr;
  fklwe_byte_t key_data;
  logic move_wr;
  logic [ADDR_W-1:0] move_addr;
  fklwe_byte_t move_data;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic stall_q;
  logic dis_q;
  logic [31:0] rd_mux;

  wire sel_ctrl = paddr == `FKLWE_CTRL_OFF;
  wire sel_key = paddr == `FKLWE_KEY_OFF;
  wire sel_addr = paddr == `FKLWE_ADDR_OFF;
  wire sel_data = paddr == `FKLWE_DATA_OFF;
  wire sel_stat = paddr == `FKLWE_STAT_OFF;
  wire sel_irq = paddr == `FKLWE_IRQ_OFF;
  wire sel_mask = paddr == `FKLWE_MASK_OFF;
  wire mapped = sel_ctrl | sel_key | sel_addr | sel_data | sel_stat | sel_irq | sel_mask;
  // no access completes while the flash is busy or a move is in flight;
  // one more cycle after busy falls lets the read flop pick up fresh status
  wire ready = ~(bus.stall | move_wr | stall_q);
  wire done = psel & penable & ready;
  wire wr_ok = done & pwrite & mapped;
  wire rd_irq = done & ~pwrite & sel_irq;
  wire ev_done = stall_q & ~bus.stall;
  wire ev_lock = bus.disabled & ~dis_q;
  wire [2:0] events = {ev_lock, bus.flash_error_reset, ev_done};
  wire [2:0] status = {bus.disabled, bus.unlocked, bus.stall};

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (sel_ctrl)
    begin
      rd_mux[`FKLWE_CTRL_WE_BIT] = we_bit;
      rd_mux[`FKLWE_CTRL_EE_BIT] = ee_bit;
    end
    if (sel_addr)
      rd_mux[ADDR_W-1:0] = move_addr;
    if (sel_stat)
      rd_mux[2:0] = status;
    if (sel_irq)
      rd_mux[2:0] = irq_stat;
    if (sel_mask)
      rd_mux[2:0] = irq_mask;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      we_bit <= 1'b0;
      ee_bit <= 1'b0;
      irq_mask <= `FKLWE_IRQ_RESET;
      move_addr <= '0;
    end
    else if (wr_ok)
    begin
      if (sel_ctrl)
      begin
        we_bit <= pwdata[`FKLWE_CTRL_WE_BIT];
        ee_bit <= pwdata[`FKLWE_CTRL_EE_BIT];
      end
      if (sel_mask)
        irq_mask <= pwdata[2:0];
      if (sel_addr)
        move_addr <= pwdata[ADDR_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      key_wr <= 1'b0;
      key_data <= 8'h00;
      move_wr <= 1'b0;
      move_data <= 8'h00;
    end
    else
    begin
      key_wr <= wr_ok & sel_key;
      move_wr <= wr_ok & sel_data;
      if (wr_ok & sel_key)
        key_data <= pwdata[7:0];
      if (wr_ok & sel_data)
        move_data <= pwdata[7:0];
    end
  end

  // read data is refreshed until the access completes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel & ~done)
      prdata <= rd_mux;
  end

  // only the bits shown to the reader are cleared; new events win
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat <= `FKLWE_IRQ_RESET;
      stall_q <= 1'b0;
      dis_q <= 1'b0;
      system_reset_req <= 1'b0;
    end
    else
    begin
      irq_stat <= (irq_stat & ~(rd_irq ? prdata[2:0] : 3'h0)) | events;
      stall_q <= bus.stall;
      dis_q <= bus.disabled;
      system_reset_req <= bus.flash_error_reset;
    end
  end

  assign pready = ready;
  assign pslverr = psel & penable & ready & ~mapped;
  assign irq = |(irq_stat & irq_mask);
  assign bus.flash_write_enable = we_bit;
  assign bus.flash_erase_enable = ee_bit;
  assign bus.key_wr = key_wr;
  assign bus.key_data = key_data;
  assign bus.move_wr = move_wr;
  assign bus.move_addr = move_addr;
  assign bus.move_data = move_data;
endmodule

// *** verilog/fklwe_defs.svh ***
// constants of the flash key-lock write/erase sequencer
`ifndef FKLWE_DEFS_SVH
`define FKLWE_DEFS_SVH
`define FKLWE_KEY_FIRST 8'hA5
`define FKLWE_KEY_SECOND 8'hF1
`define FKLWE_PAGE_BYTES 512
`define FKLWE_ERASED_BYTE 8'hFF
`define FKLWE_PROG_CYCLES 16
`define FKLWE_CTRL_OFF 12'h000
`define FKLWE_KEY_OFF 12'h004
`define FKLWE_ADDR_OFF 12'h008
`define FKLWE_DATA_OFF 12'h00C
`define FKLWE_STAT_OFF 12'h010
`define FKLWE_IRQ_OFF 12'h014
`define FKLWE_MASK_OFF 12'h018
`define FKLWE_CTRL_WE_BIT 0
`define FKLWE_CTRL_EE_BIT 1
`define FKLWE_ST_BUSY_BIT 0
`define FKLWE_ST_UNLK_BIT 1
`define FKLWE_ST_DIS_BIT 2
`define FKLWE_IRQ_DONE_BIT 0
`define FKLWE_IRQ_FERR_BIT 1
`define FKLWE_IRQ_LOCK_BIT 2
`define FKLWE_IRQ_RESET 3'h0
`endif

// *** verilog/fklwe_pkg.sv ***
// types of the flash key-lock write/erase sequencer
package fklwe_pkg;
  typedef logic [7:0] fklwe_byte_t;
  typedef enum logic [1:0] {KEY_IDLE, KEY_FIRST, KEY_UNLOCKED, KEY_DISABLED} fklwe_key_e;
  typedef enum logic [1:0] {OP_IDLE, OP_PROG, OP_ERASE} fklwe_op_e;
endpackage

// *** verilog/fklwe_if.sv ***
// link between the processor-side end and the flash sequencer
interface fklwe_if #(parameter int ADDR_W = 16);
  logic flash_write_enable;
  logic flash_erase_enable;
  logic key_wr;
  logic [7:0] key_data;
  logic move_wr;
  logic [ADDR_W-1:0] move_addr;
  logic [7:0] move_data;
  logic stall;
  logic flash_error_reset;
  logic unlocked;
  logic disabled;
  modport core (
    output flash_write_enable, flash_erase_enable, key_wr, key_data,
    output move_wr, move_addr, move_data,
    input stall, flash_error_reset, unlocked, disabled
  );
  modport dev (
    input flash_write_enable, flash_erase_enable, key_wr, key_data,
    input move_wr, move_addr, move_data,
    output stall, flash_error_reset, unlocked, disabled
  );
endinterface

// *** verilog/fklwe_key_fsm.sv ***
// key checker: two ordered codes unlock exactly one flash operation
`include "fklwe_defs.svh"
module fklwe_key_fsm
  import fklwe_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic key_wr,
  input wire fklwe_byte_t key_data,
  input wire logic op_attempt,
  output logic unlocked,
  output logic disabled
);
  fklwe_key_e state;
  fklwe_key_e next_state;
  wire first_ok = key_data == `FKLWE_KEY_FIRST;
  wire second_ok = key_data == `FKLWE_KEY_SECOND;

  // any spacing between codes is fine: states wait without timeout
  always_comb
  begin
    next_state = state;
    unique case (state)
      KEY_IDLE:
      begin
        if (op_attempt)
          next_state = KEY_DISABLED;
        else if (key_wr)
          next_state = first_ok ? KEY_FIRST : KEY_DISABLED;
      end
      KEY_FIRST:
      begin
        if (op_attempt)
          next_state = KEY_DISABLED;
        else if (key_wr)
          next_state = second_ok ? KEY_UNLOCKED : KEY_DISABLED;
      end
      KEY_UNLOCKED:
      begin
        if (op_attempt)
          next_state = KEY_IDLE;
        else if (key_wr)
          next_state = KEY_DISABLED;
      end
      KEY_DISABLED: next_state = KEY_DISABLED;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= KEY_IDLE;
    else
      state <= next_state;
  end

  assign unlocked = state == KEY_UNLOCKED;
  assign disabled = state == KEY_DISABLED;
endmodule

// *** verilog/fklwe_dev.sv ***
// flash sequencer end: key lock, byte program, page erase, flash array
// Notes on behaviour
// - programming only clears bits; erase sets them
// - writes and erases are timed internally
// - execution stalls while an operation runs
// - write enable routes move writes to flash
// - write enable clears only by software
// - bad supply monitor makes attempt reset device
// - keys must come first then second code
// - any spacing between the two keys
// - wrong or misordered key locks out until reset
// - attempt without keys locks out until reset
// - lock re-arms after every operation
// - erase sets whole page to erased value
// - both enables plus keys: write erases page
// - software repeats keys per page, clears enables
// - software masks interrupts around erase sequence
// - write enable alone programs a single byte
// - erase needs both enables set
`include "fklwe_defs.svh"
module fklwe_dev
  import fklwe_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int PAGES = 2
)
(
  input wire logic pclk,
  input wire logic presetn,
  fklwe_if.dev bus,
  input wire logic vdd_monitor_on,
  input wire logic vdd_monitor_reset_src,
  input wire logic [ADDR_W-1:0] rd_addr,
  output fklwe_byte_t rd_data,
  output logic busy
);
  localparam int CNT_W = $clog2(`FKLWE_PAGE_BYTES);
  localparam int DEPTH = PAGES * `FKLWE_PAGE_BYTES;
  localparam int AW = $clog2(DEPTH);
  localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(`FKLWE_PROG_CYCLES - 1);
  localparam logic [CNT_W-1:0] PAGE_LAST = CNT_W'(`FKLWE_PAGE_BYTES - 1);

  fklwe_byte_t mem [DEPTH];
  fklwe_op_e state;
  fklwe_op_e next_state;
  logic [CNT_W-1:0] cnt;
  logic [AW-1:0] op_addr;
  fklwe_byte_t op_data;
  logic err_pulse;
  logic key_unlocked;
  logic key_disabled;

  // the enables are only read here; they live on the processor side
  wire attempt = bus.move_wr & bus.flash_write_enable;
  wire idle = state == OP_IDLE;
  wire supply_ok = vdd_monitor_on & vdd_monitor_reset_src;
  wire go = attempt & idle & key_unlocked & supply_ok;
  wire erase_go = go & bus.flash_erase_enable;
  wire prog_go = go & ~bus.flash_erase_enable;
  wire prog_last = state == OP_PROG && cnt == PROG_LAST;
  wire erase_last = state == OP_ERASE && cnt == PAGE_LAST;
  wire [AW-1:0] target = bus.move_addr[AW-1:0];
  wire [AW-1:0] erase_addr = {op_addr[AW-1:CNT_W], cnt};
  wire mem_we = prog_last | (state == OP_ERASE);
  wire [AW-1:0] mem_waddr = (state == OP_ERASE) ? erase_addr : op_addr;
  wire fklwe_byte_t prog_val = mem[op_addr] & op_data;
  wire fklwe_byte_t mem_wdata = (state == OP_ERASE) ? `FKLWE_ERASED_BYTE : prog_val;

  fklwe_key_fsm u_key (
    .pclk(pclk),
    .presetn(presetn),
    .key_wr(bus.key_wr),
    .key_data(bus.key_data),
    .op_attempt(attempt & idle),
    .unlocked(key_unlocked),
    .disabled(key_disabled)
  );

  always_comb
  begin
    next_state = state;
    unique case (state)
      OP_IDLE:
      begin
        if (erase_go)
          next_state = OP_ERASE;
        else if (prog_go)
          next_state = OP_PROG;
      end
      OP_PROG:
      begin
        if (prog_last)
          next_state = OP_IDLE;
      end
      OP_ERASE:
      begin
        if (erase_last)
          next_state = OP_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= OP_IDLE;
    else
      state <= next_state;
  end

  // one counter paces programming and walks the page during erase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt <= '0;
    else if (idle)
      cnt <= '0;
    else
      cnt <= cnt + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_addr <= '0;
      op_data <= 8'h00;
    end
    else if (go)
    begin
      op_addr <= target;
      op_data <= bus.move_data;
    end
  end

  // a move write with a bad supply monitor never touches the array
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      err_pulse <= 1'b0;
    else
      err_pulse <= attempt & idle & ~supply_ok;
  end

  // array is non-volatile and therefore has no reset
  always_ff @(posedge pclk)
  begin
    if (mem_we)
      mem[mem_waddr] <= mem_wdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rd_data <= 8'h00;
    else
      rd_data <= mem[rd_addr[AW-1:0]];
  end

  assign bus.stall = ~idle;
  assign busy = ~idle;
  assign bus.flash_error_reset = err_pulse;
  assign bus.unlocked = key_unlocked;
  assign bus.disabled = key_disabled;
endmodule

// *** test/fklwe_chk_sva.sv ***
// link checks between the core end and the flash sequencer end
module fklwe_chk_sva
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flash_write_enable,
  input wire logic flash_erase_enable,
  input wire logic key_wr,
  input wire logic [7:0] key_data,
  input wire logic move_wr,
  input wire logic stall,
  input wire logic flash_error_reset,
  input wire logic unlocked,
  input wire logic disabled
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [7:0] last_key;
  logic [9:0] stall_len;
  // last key value seen, and how long the current stall has lasted
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_key <= 8'h00;
      stall_len <= 10'h000;
    end
    else
    begin
      if (key_wr)
        last_key <= key_data;
      stall_len <= stall ? stall_len + 10'h001 : 10'h000;
    end
  end
  sequence s_key_pair;
    key_wr && key_data == 8'hF1 && last_key == 8'hA5 && !unlocked && !disabled;
  endsequence
  sequence s_granted_op;
    move_wr && flash_write_enable ##0 unlocked;
  endsequence
  chk_pair_unlocks: assert property (s_key_pair |=> unlocked)
    else $error("key pair did not unlock");
  chk_bad_key_locks: assert property (
    key_wr && key_data != 8'hA5 && key_data != 8'hF1 |=> disabled)
    else $error("wrong key did not lock out");
  chk_lock_sticky: assert property (disabled |=> disabled)
    else $error("lockout left without reset");
  chk_early_attempt: assert property (
    move_wr && flash_write_enable && !unlocked |=> disabled)
    else $error("attempt without keys did not lock out");
  chk_op_relocks: assert property (
    s_granted_op |=> !unlocked && (stall || flash_error_reset))
    else $error("granted operation did not start and relock");
  chk_we_gates_move: assert property (
    move_wr && !flash_write_enable && !stall |=> !stall && !flash_error_reset)
    else $error("move write reached flash without write enable");
  chk_op_length: assert property (
    $fell(stall) |-> stall_len == (flash_erase_enable ? 10'h200 : 10'h010))
    else $error("operation length wrong");
  chk_error_pulse: assert property (
    flash_error_reset |=> !flash_error_reset && !stall)
    else $error("flash error pulse malformed");
  chk_enables_kept: assert property (
    stall |-> $stable(flash_write_enable) && $stable(flash_erase_enable))
    else $error("enable bits changed during operation");
endmodule

// *** test/tb.sv ***
// self-checking bench: APB core end driving the flash sequencer end
`include "fklwe_defs.svh"
module tb
  import fklwe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, system_reset_req;
  logic vdd_on, vdd_src, busy, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] rd_addr;
  fklwe_byte_t rd_data;
  int miscompares, n_compared, rst_cnt;
  fklwe_if #(.ADDR_W(16)) fklwe_if_inst ();
  fklwe_core #(.ADDR_W(16)) fklwe_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .system_reset_req(system_reset_req),
    .bus(fklwe_if_inst));
  fklwe_dev #(.ADDR_W(16), .PAGES(2)) fklwe_dev_inst (.pclk(pclk), .presetn(presetn),
    .bus(fklwe_if_inst), .vdd_monitor_on(vdd_on), .vdd_monitor_reset_src(vdd_src),
    .rd_addr(rd_addr), .rd_data(rd_data), .busy(busy));
  fklwe_chk_sva fklwe_chk_sva_inst (.pclk(pclk), .presetn(presetn),
    .flash_write_enable(fklwe_if_inst.flash_write_enable),
    .flash_erase_enable(fklwe_if_inst.flash_erase_enable), .key_wr(fklwe_if_inst.key_wr),
    .key_data(fklwe_if_inst.key_data), .move_wr(fklwe_if_inst.move_wr),
    .stall(fklwe_if_inst.stall), .flash_error_reset(fklwe_if_inst.flash_error_reset),
    .unlocked(fklwe_if_inst.unlocked), .disabled(fklwe_if_inst.disabled));
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk)
    if (system_reset_req === 1'b1)
      rst_cnt <= rst_cnt + 1;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one APB transfer; pready and read data are taken at the completing rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(r, exp);
  endtask
  task automatic keys(input int gap);
    wr(`FKLWE_KEY_OFF, 32'h000000A5);
    repeat (gap) @(posedge pclk);
    wr(`FKLWE_KEY_OFF, 32'h000000F1);
  endtask
  // the status read waits out the operation through pready
  task automatic mv(input logic [15:0] a, input logic [7:0] d, input logic [31:0] st);
    wr(`FKLWE_ADDR_OFF, {16'h0000, a});
    wr(`FKLWE_DATA_OFF, {24'h000000, d});
    rd(`FKLWE_STAT_OFF, st);
  endtask
  task automatic fl(input logic [15:0] a, input logic [7:0] exp);
    @(posedge pclk);
    rd_addr <= a;
    @(posedge pclk);
    @(negedge pclk);
    check({24'h000000, rd_data}, {24'h000000, exp});
  endtask
  task automatic irq_is(input logic exp);
    @(negedge pclk);
    check({31'h0, irq}, {31'h0, exp});
  endtask
  initial
  begin
    #2000000;
    miscompares++;
    $display("[ERR] %0t: watchdog expired", $time);
    tally_and_finish();
  end
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    vdd_on = 1'b1;
    vdd_src = 1'b1;
    rd_addr = 16'h0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`FKLWE_CTRL_OFF, 32'h0);
    rd(`FKLWE_MASK_OFF, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    mv(16'h0003, 8'h00, 32'h0);
    rd(`FKLWE_ADDR_OFF, 32'h3);
    $display("test registers done");
    wr(`FKLWE_MASK_OFF, 32'h7);
    rd(`FKLWE_MASK_OFF, 32'h7);
    wr(`FKLWE_MASK_OFF, 32'h0);
    wr(`FKLWE_CTRL_OFF, 32'h3);
    for (int p = 0; p < 2; p++)
    begin
      keys(0);
      mv(16'(p * 512 + 16), 8'h5A, 32'h0);
      fl(16'(p * 512), 8'hFF);
      fl(16'(p * 512 + 511), 8'hFF);
      irq_is(1'b0);
    end
    wr(`FKLWE_CTRL_OFF, 32'h0);
    rd(`FKLWE_CTRL_OFF, 32'h0);
    wr(`FKLWE_MASK_OFF, 32'h7);
    irq_is(1'b1);
    rd(`FKLWE_IRQ_OFF, 32'h1);
    irq_is(1'b0);
    $display("test erase done");
    wr(`FKLWE_CTRL_OFF, 32'h1);
    keys(20);
    wr(`FKLWE_ADDR_OFF, 32'h00000005);
    wr(`FKLWE_DATA_OFF, 32'h0000003C);
    repeat (2) @(posedge pclk);
    check({31'h0, busy}, 32'h1);
    rd(`FKLWE_STAT_OFF, 32'h0);
    fl(16'h0005, 8'h3C);
    keys(0);
    mv(16'h0005, 8'hC3, 32'h0);
    fl(16'h0005, 8'h00);
    fl(16'h0004, 8'hFF);
    rd(`FKLWE_CTRL_OFF, 32'h1);
    rd(`FKLWE_IRQ_OFF, 32'h1);
    $display("test program done");
    wr(`FKLWE_MASK_OFF, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      vdd_on <= (i != 0);
      vdd_src <= (i == 0);
      keys(0);
      mv(16'h0006, 8'h00, 32'h0);
      fl(16'h0006, 8'hFF);
      irq_is(1'b0);
      rd(`FKLWE_IRQ_OFF, 32'h2);
    end
    check(rst_cnt, 32'h2);
    vdd_on <= 1'b1;
    vdd_src <= 1'b1;
    $display("test supply done");
    for (int i = 0; i < 3; i++)
    begin
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      wr(`FKLWE_CTRL_OFF, 32'h1);
      wr(`FKLWE_MASK_OFF, 32'h4);
      if (i == 0)
        wr(`FKLWE_KEY_OFF, 32'h00000012);
      else if (i == 1)
        wr(`FKLWE_KEY_OFF, 32'h000000F1);
      else
        mv(16'h0007, 8'h00, 32'h4);
      rd(`FKLWE_STAT_OFF, 32'h4);
      irq_is(1'b1);
      rd(`FKLWE_IRQ_OFF, 32'h4);
      keys(0);
      mv(16'h0007, 8'h00, 32'h4);
      fl(16'h0007, 8'hFF);
    end
    $display("test lockout done");
    tally_and_finish();
  end
endmodule
